// ==== hdl/tmc_core.sv ====
// Purpose: control core of a timer: counter control, master output, idle levels
// Assumes: counter, slave controller and channels live outside and feed pulses
// Notes: register port answers reads one cycle later and never stalls
// How it works
// - debug halt freezes the counter when the stop configuration bit is set
// - registers accept half-word and word accesses through byte enables
// - reload value written directly, or buffered until update when preloaded
// - centre alignment gates compare flags to down, up or both directions
// - edge alignment outside encoder mode uses direction bit; it is read-only otherwise
// - single pulse mode clears counter enable at the next update event
// - update source bit limits update requests to overflow or underflow
// - update event from overflow, software or slave loads the reload shadow register
// - update disable blocks update events but still reinitialises counter
// - trigger mode sets counter enable in hardware on the trigger
// - with main output off, outputs take idle levels after dead-time
// - idle level writes are ignored while any lock level is set
// - timer input 1 is channel pin 0 or XOR of three pins
// - master select 000 sends software update, slave reset one cycle late
// - master select 001 sends counter run signal, gated part delayed unless master/slave sync is on
// - master select 010 sends the update event
// - master select 011 pulses on every channel 1 capture or compare
// - master selects 100 to 111 send compare references 0 to 3
// - channel DMA requests follow channel events or the update event
// - commutation on software bit, or also on trigger rising edge
// - channel control bits preloaded take effect only at commutation
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
module tmc_core #(
    parameter int RLD_W = 16,
    parameter int CHC_W = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire tmc_pkg::tmc_bus_req_t reg_req_i,
    output logic [31:0] reg_rdata_o,
    input wire logic debug_halt_i,
    input wire logic debug_stop_cfg_i,
    input wire logic overflow_i,
    input wire logic software_update_generate_i,
    input wire logic slave_reset_i,
    input wire logic slave_update_i,
    input wire logic encoder_mode_i,
    input wire logic trigger_mode_i,
    input wire logic gated_mode_i,
    input wire logic trigger_input_i,
    input wire logic trigger_edge_i,
    input wire logic master_slave_sync_i,
    input wire logic count_down_i,
    input wire logic [1:0] lock_level_i,
    input wire logic main_output_enable_i,
    input wire logic dead_time_done_i,
    input wire logic [6:0] chan_drive_i,
    input wire logic [2:0] chan_pins_i,
    input wire logic channel1_flag_set_i,
    input wire logic [3:0] cc_event_i,
    input wire logic [3:0] compare_ref_i,
    input wire logic software_commutation_i,
    output logic counter_run_signal_o,
    output logic count_down_o,
    output logic [1:0] alignment_o,
    output logic cmp_flag_enable_o,
    output logic update_event_o,
    output logic update_req_o,
    output logic counter_reinit_o,
    output logic [RLD_W-1:0] auto_reload_value_o,
    output logic [CHC_W-1:0] chan_ctrl_o,
    output logic commutation_o,
    output logic [6:0] chan_out_o,
    output logic ti1_o,
    output logic trigger_output_o,
    output logic [3:0] cc_dma_req_o,
    output logic sample_tick_o
);

    tmc_pkg::tmc_cnt_ctrl_t ctl1_q;
    tmc_pkg::tmc_out_ctrl_t ctl2_q;
    logic [RLD_W-1:0] rld_pre_q;
    logic [RLD_W-1:0] rld_q;
    logic [CHC_W-1:0] chc_pre_q;
    logic [CHC_W-1:0] chc_q;
    logic [31:0] rdata_q;
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [2:0] pin_s3_q;
    logic [2:0] pin_q;
    logic [1:0] div_cnt_q;
    logic [1:0] div_last;
    logic slave_reset_q;
    logic gate_q;
    logic trg_q;
    logic [6:0] out_q;
    logic [3:0] dma_q;
    logic [15:0] wmask;
    logic [15:0] wlane;
    logic wr_ctl1;
    logic wr_ctl2;
    logic wr_rld;
    logic wr_chc;
    logic upd_ev;
    logic com_ev;
    logic dir_free;
    logic gate_sel;
    logic run_raw;
    tmc_pkg::tmc_cnt_ctrl_t ctl1_w;
    tmc_pkg::tmc_out_ctrl_t ctl2_w;

    // byte enables pick the lanes, so half-word and word writes both land
    assign wmask = {{8{reg_req_i.be[1]}}, {8{reg_req_i.be[0]}}};
    assign wlane = reg_req_i.wdata[15:0];
    assign wr_ctl1 = reg_req_i.wr && (reg_req_i.addr == tmc_pkg::OFS_COUNTER_CONTROL);
    assign wr_ctl2 = reg_req_i.wr && (reg_req_i.addr == tmc_pkg::OFS_OUTPUT_MASTER);
    assign wr_rld = reg_req_i.wr && (reg_req_i.addr == tmc_pkg::OFS_AUTO_RELOAD);
    assign wr_chc = reg_req_i.wr && (reg_req_i.addr == tmc_pkg::OFS_CHAN_CTRL);

    // update event and its request; reinit happens even when events are blocked
    assign upd_ev = !ctl1_q.update_disable
        && (overflow_i || software_update_generate_i || slave_update_i);
    assign update_req_o = upd_ev && (!ctl1_q.update_source_select || overflow_i);
    assign update_event_o = upd_ev;
    assign counter_reinit_o = software_update_generate_i || slave_reset_i;

    // direction bit is only writable in edge alignment outside encoder mode
    assign dir_free = (ctl1_q.alignment_select == tmc_pkg::ALIGN_EDGE) && !encoder_mode_i;

    // merged write value of the counter control register
    always_comb begin
        ctl1_w = (ctl1_q & ~wmask) | (wlane & wmask & tmc_pkg::MASK_COUNTER_CONTROL);
        if (!dir_free) begin
            ctl1_w.dir = ctl1_q.dir;
        end
    end

    // counter control: software write, single-pulse stop, trigger start
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctl1_q <= tmc_pkg::RESET_VALUE;
        end else begin
            ctl1_q <= wr_ctl1 ? ctl1_w : ctl1_q;
            if (ctl1_q.single_pulse_mode && upd_ev) begin
                ctl1_q.counter_enable_bit <= 1'b0;
            end
            // a trigger in the same cycle wins so a start is never lost
            if (trigger_mode_i && trigger_edge_i) begin
                ctl1_q.counter_enable_bit <= 1'b1;
            end
        end
    end

    // merged write value of the output and master control register
    always_comb begin
        ctl2_w = (ctl2_q & ~wmask) | (wlane & wmask & tmc_pkg::MASK_OUTPUT_MASTER);
        if (lock_level_i != tmc_pkg::LOCK_OFF) begin
            ctl2_w.idle_levels = ctl2_q.idle_levels;
        end
    end

    // output and master control register
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctl2_q <= tmc_pkg::RESET_VALUE;
        end else if (wr_ctl2) begin
            ctl2_q <= ctl2_w;
        end
    end

    // reload value: preload always written, shadow direct or at update
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rld_pre_q <= '0;
            rld_q <= '0;
        end else begin
            if (wr_rld) begin
                rld_pre_q <= (rld_pre_q & RLD_W'(~wmask)) | RLD_W'(wlane & wmask);
            end
            if (wr_rld && !ctl1_q.reload_preload_enable) begin
                rld_q <= (rld_pre_q & RLD_W'(~wmask)) | RLD_W'(wlane & wmask);
            end else if (upd_ev) begin
                rld_q <= rld_pre_q;
            end
        end
    end

    // commutation event from the software bit or, optionally, the trigger edge
    assign com_ev = software_commutation_i
        || (ctl2_q.commutation_source_select && trigger_edge_i);

    // channel control bits: immediate, or held until a commutation event
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            chc_pre_q <= '0;
            chc_q <= '0;
        end else begin
            if (wr_chc) begin
                chc_pre_q <= (chc_pre_q & CHC_W'(~wmask)) | CHC_W'(wlane & wmask);
            end
            if (!ctl2_q.channel_control_preload) begin
                chc_q <= wr_chc ? ((chc_pre_q & CHC_W'(~wmask)) | CHC_W'(wlane & wmask))
                    : chc_pre_q;
            end else if (com_ev) begin
                chc_q <= chc_pre_q;
            end
        end
    end
    assign chan_ctrl_o = chc_q;
    assign commutation_o = com_ev;
    assign auto_reload_value_o = rld_q;

    // read path; unmapped offsets and the upper half read as zero
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                tmc_pkg::OFS_COUNTER_CONTROL:
                    rdata_q <= {16'h0000, ctl1_q[15:5], count_down_o, ctl1_q[3:0]};
                tmc_pkg::OFS_OUTPUT_MASTER: rdata_q <= {16'h0000, ctl2_q};
                tmc_pkg::OFS_AUTO_RELOAD: rdata_q <= 32'(rld_pre_q);
                tmc_pkg::OFS_CHAN_CTRL: rdata_q <= 32'(chc_pre_q);
                default: rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end
    assign reg_rdata_o = rdata_q;

    // counter run: enable bit OR gated trigger, frozen by debug halt if asked
    assign gate_sel = gated_mode_i && trigger_input_i;
    assign run_raw = ctl1_q.counter_enable_bit || gate_sel;
    assign counter_run_signal_o = run_raw && !(debug_halt_i && debug_stop_cfg_i);

    // direction seen by the counter, and the compare flag gate
    assign count_down_o = dir_free ? ctl1_q.dir : count_down_i;
    assign alignment_o = ctl1_q.alignment_select;
    always_comb begin
        unique case (ctl1_q.alignment_select)
            tmc_pkg::ALIGN_DOWN: cmp_flag_enable_o = count_down_i;
            tmc_pkg::ALIGN_UP: cmp_flag_enable_o = !count_down_i;
            default: cmp_flag_enable_o = 1'b1;
        endcase
    end

    // channel pins: three flops, a change counts once stages two and three agree
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            pin_s3_q <= 3'h0;
            pin_q <= 3'h0;
        end else begin
            pin_s1_q <= chan_pins_i;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_q <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));
        end
    end
    assign ti1_o = ctl2_q.input_combine_select ? ^pin_q : pin_q[0];

    // idle levels after dead-time; registered so pins never glitch on a mux
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            out_q <= 7'h00;
        end else if (!main_output_enable_i && dead_time_done_i) begin
            out_q <= ctl2_q.idle_levels;
        end else begin
            out_q <= chan_drive_i;
        end
    end
    assign chan_out_o = out_q;

    // delay stages for the slave reset and the unsynchronised gate
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            slave_reset_q <= 1'b0;
            gate_q <= 1'b0;
        end else begin
            slave_reset_q <= slave_reset_i;
            gate_q <= gate_sel;
        end
    end

    // trigger output; one register stage keeps it clean for slave timers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            trg_q <= 1'b0;
        end else begin
            unique case (ctl2_q.master_output_select)
                tmc_pkg::MOS_RESET:
                    trg_q <= software_update_generate_i || slave_reset_q;
                tmc_pkg::MOS_ENABLE:
                    trg_q <= ctl1_q.counter_enable_bit
                        || (master_slave_sync_i ? gate_sel : gate_q);
                tmc_pkg::MOS_UPDATE: trg_q <= upd_ev;
                tmc_pkg::MOS_CMP_PULSE: trg_q <= channel1_flag_set_i;
                tmc_pkg::MOS_REF0: trg_q <= compare_ref_i[0];
                tmc_pkg::MOS_REF1: trg_q <= compare_ref_i[1];
                tmc_pkg::MOS_REF2: trg_q <= compare_ref_i[2];
                tmc_pkg::MOS_REF3: trg_q <= compare_ref_i[3];
            endcase
        end
    end
    assign trigger_output_o = trg_q;

    // channel DMA requests, timed by channel event or update event
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            dma_q <= 4'h0;
        end else begin
            dma_q <= ctl2_q.channel_dma_timing ? {4{upd_ev}} : cc_event_i;
        end
    end
    assign cc_dma_req_o = dma_q;

    // sample clock divider; the reserved code runs undivided
    always_comb begin
        unique case (ctl1_q.sample_clock_division)
            tmc_pkg::DIV_BY2: div_last = tmc_pkg::LAST_BY2;
            tmc_pkg::DIV_BY4: div_last = tmc_pkg::LAST_BY4;
            default: div_last = tmc_pkg::LAST_BY1;
        endcase
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt_q <= 2'h0;
        end else if (div_cnt_q >= div_last) begin
            div_cnt_q <= 2'h0;
        end else begin
            div_cnt_q <= div_cnt_q + 2'h1;
        end
    end
    assign sample_tick_o = (div_cnt_q >= div_last);

    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_debug_freeze: assert property (
        debug_halt_i && debug_stop_cfg_i |-> !counter_run_signal_o)
        else $error("counter runs in debug halt");
    a_reload_direct: assert property (
        wr_rld && !ctl1_q.reload_preload_enable && reg_req_i.be[1:0] == 2'h3
        |=> rld_q == $past(reg_req_i.wdata[RLD_W-1:0]))
        else $error("direct reload not applied");
    a_reload_buffered: assert property (
        ctl1_q.reload_preload_enable && !upd_ev |=> $stable(rld_q))
        else $error("buffered reload moved");
    a_flag_gate: assert property (
        ctl1_q.alignment_select == tmc_pkg::ALIGN_UP
        |-> cmp_flag_enable_o == !count_down_i)
        else $error("flag gate wrong");
    a_dir_locked: assert property (
        !dir_free ##1 !dir_free |-> $stable(ctl1_q.dir))
        else $error("direction written in locked mode");
    a_single_pulse: assert property (
        ctl1_q.single_pulse_mode && upd_ev && !wr_ctl1
        && !(trigger_mode_i && trigger_edge_i) |=> !ctl1_q.counter_enable_bit)
        else $error("single pulse did not stop");
    a_update_source: assert property (
        ctl1_q.update_source_select && !overflow_i |-> !update_req_o)
        else $error("update request from wrong source");
    a_update_block: assert property (
        ctl1_q.update_disable
        |-> !update_event_o && (!software_update_generate_i || counter_reinit_o))
        else $error("update not blocked");
    a_trigger_start: assert property (
        trigger_mode_i && trigger_edge_i |=> ctl1_q.counter_enable_bit)
        else $error("trigger did not start");
    a_idle_lock: assert property (
        lock_level_i != tmc_pkg::LOCK_OFF |=> $stable(ctl2_q.idle_levels))
        else $error("idle level changed under lock");
    a_trigger_update: assert property (
        ctl2_q.master_output_select == tmc_pkg::MOS_UPDATE && $stable(ctl2_q)
        |-> trigger_output_o == $past(upd_ev))
        else $error("trigger output misses update");
    a_com_preload: assert property (
        ctl2_q.channel_control_preload && !com_ev |=> $stable(chc_q))
        else $error("channel bits moved without commutation");
    // a write in the tick cycle may change the ratio, so it is left out
    a_tick_period: assert property (
        ctl1_q.sample_clock_division == tmc_pkg::DIV_BY2 && !wr_ctl1
        && $stable(ctl1_q.sample_clock_division) && sample_tick_o |=> !sample_tick_o)
        else $error("divide by two ticks too often");

    c_single_pulse: cover property (ctl1_q.single_pulse_mode && upd_ev);
    c_trigger_start: cover property (trigger_mode_i && trigger_edge_i);
    c_commutation: cover property (ctl2_q.channel_control_preload && com_ev);
    c_idle_out: cover property (!main_output_enable_i && dead_time_done_i);

endmodule

// ==== hdl/tmc_pkg.sv ====
// Purpose: shared constants and types of the timer master control core
// Assumes: registers are 16 bits wide and sit in the low half of a 32-bit word
// Notes: field layouts follow the bit order of the two control registers
package tmc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_COUNTER_CONTROL = 8'h00;
    localparam logic [7:0] OFS_OUTPUT_MASTER = 8'h04;
    localparam logic [7:0] OFS_AUTO_RELOAD = 8'h2C;
    localparam logic [7:0] OFS_CHAN_CTRL = 8'h30;
    localparam logic [15:0] RESET_VALUE = 16'h0000;
    // writable bits; reserved bits read as zero
    localparam logic [15:0] MASK_COUNTER_CONTROL = 16'h03FF;
    localparam logic [15:0] MASK_OUTPUT_MASTER = 16'h7FFD;
    // alignment codes
    localparam logic [1:0] ALIGN_EDGE = 2'h0;
    localparam logic [1:0] ALIGN_DOWN = 2'h1;
    localparam logic [1:0] ALIGN_UP = 2'h2;
    localparam logic [1:0] ALIGN_BOTH = 2'h3;
    // sample clock division codes and their terminal counts
    localparam logic [1:0] DIV_BY1 = 2'h0;
    localparam logic [1:0] DIV_BY2 = 2'h1;
    localparam logic [1:0] DIV_BY4 = 2'h2;
    localparam logic [1:0] LAST_BY1 = 2'h0;
    localparam logic [1:0] LAST_BY2 = 2'h1;
    localparam logic [1:0] LAST_BY4 = 2'h3;
    localparam logic [1:0] LOCK_OFF = 2'h0;
    // master output selection
    typedef enum logic [2:0] {
        MOS_RESET = 3'h0,
        MOS_ENABLE = 3'h1,
        MOS_UPDATE = 3'h2,
        MOS_CMP_PULSE = 3'h3,
        MOS_REF0 = 3'h4,
        MOS_REF1 = 3'h5,
        MOS_REF2 = 3'h6,
        MOS_REF3 = 3'h7
    } tmc_mos_t;
    typedef struct packed {
        logic [5:0] rsvd;
        logic [1:0] sample_clock_division;
        logic reload_preload_enable;
        logic [1:0] alignment_select;
        logic dir;
        logic single_pulse_mode;
        logic update_source_select;
        logic update_disable;
        logic counter_enable_bit;
    } tmc_cnt_ctrl_t;
    typedef struct packed {
        logic rsvd15;
        logic [6:0] idle_levels; // ch3, ch2n, ch2, ch1n, ch1, ch0n, ch0
        logic input_combine_select;
        tmc_mos_t master_output_select;
        logic channel_dma_timing;
        logic commutation_source_select;
        logic rsvd1;
        logic channel_control_preload;
    } tmc_out_ctrl_t;
    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
        logic wr;
        logic rd;
    } tmc_bus_req_t;
endpackage

// ==== tb/tmc_slave_model.sv ====
// Purpose: slave timer that uses the master trigger output as its prescaler
// Assumes: trigger output is a registered level from the master core
// Notes: counts rising edges only, so a held level counts once
`timescale 1ns/10ps
module tmc_slave_model (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic trigger_input_i,
    output logic [7:0] edges_o
);
    logic prev_q;
    // each rising edge of the master trigger advances the slave count
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            prev_q <= 1'h0;
            edges_o <= 8'h00;
        end else begin
            prev_q <= trigger_input_i;
            if (trigger_input_i && !prev_q) begin
                edges_o <= edges_o + 8'h01;
            end
        end
    end
endmodule

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the timer master control core
// Assumes: register reads answer in the cycle after the read strobe
// Notes: tasks start and end on a rising edge; pulses are judged mid-cycle
`timescale 1ns/10ps
module tb;
    logic clk_sys_i = 1'h0;
    logic rst_i = 1'h1;
    tmc_pkg::tmc_bus_req_t reg_req_i = '0;
    logic debug_halt_i = 1'h0, debug_stop_cfg_i = 1'h0, overflow_i = 1'h0;
    logic software_update_generate_i = 1'h0, slave_reset_i = 1'h0, slave_update_i = 1'h0;
    logic encoder_mode_i = 1'h0, trigger_mode_i = 1'h0, gated_mode_i = 1'h0;
    logic trigger_input_i = 1'h0, trigger_edge_i = 1'h0, master_slave_sync_i = 1'h0;
    logic count_down_i = 1'h0, main_output_enable_i = 1'h0, dead_time_done_i = 1'h0;
    logic channel1_flag_set_i = 1'h0, software_commutation_i = 1'h0;
    logic [1:0] lock_level_i = 2'h0;
    logic [6:0] chan_drive_i = 7'h00;
    logic [2:0] chan_pins_i = 3'h0;
    logic [3:0] cc_event_i = 4'h0, compare_ref_i = 4'h0;
    logic [31:0] reg_rdata_o;
    logic counter_run_signal_o, count_down_o, cmp_flag_enable_o, update_event_o;
    logic update_req_o, counter_reinit_o, commutation_o, ti1_o, trigger_output_o, sample_tick_o;
    logic [1:0] alignment_o;
    logic [15:0] auto_reload_value_o, chan_ctrl_o;
    logic [6:0] chan_out_o;
    logic [3:0] cc_dma_req_o;
    logic [7:0] edges;
    int n_fail = 0;
    int n_checks = 0;

    tmc_core u_dut (.*);
    // far side: a slave timer fed by the trigger output
    tmc_slave_model u_slave (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .trigger_input_i(trigger_output_o), .edges_o(edges));

    initial forever #50 clk_sys_i = ~clk_sys_i;

    task automatic step();
        @(posedge clk_sys_i);
    endtask
    task automatic mid();
        @(negedge clk_sys_i);
    endtask
    // compare and count; four-state equality so an unknown matches only an unknown
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle write; an idle edge follows so strobes never collide
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_req_i <= '{a, {16'h0000, d}, 4'hF, 1'h1, 1'h0};
        step();
        reg_req_i.wr <= 1'h0;
        step();
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        reg_req_i <= '{a, 32'h00000000, 4'hF, 1'h0, 1'h1};
        step();
        reg_req_i.rd <= 1'h0;
        mid();
        chk(reg_rdata_o, {16'h0000, exp});
        step();
    endtask
    // reset values, reserved bits, locked idle levels, unmapped place
    task automatic t_regs();
        int n;
        rdc(8'h00, 16'h0000);
        rdc(8'h04, 16'h0000);
        wr(8'h00, 16'hFF90);
        rdc(8'h00, 16'h0390);
        chk(count_down_o, 1'h1);
        encoder_mode_i <= 1'h1;
        wr(8'h00, 16'h0000);
        encoder_mode_i <= 1'h0;
        rdc(8'h00, 16'h0010);
        wr(8'h00, 16'h0000);
        wr(8'h04, 16'hFFFF);
        rdc(8'h04, 16'h7FFD);
        lock_level_i <= 2'h1;
        wr(8'h04, 16'h0000);
        rdc(8'h04, 16'h7F00);
        lock_level_i <= 2'h0;
        wr(8'h08, 16'hFFFF);
        rdc(8'h08, 16'h0000);
        // divide by 2 then by 4: ticks in any eight cycles
        for (int k = 1; k < 3; k++) begin
            wr(8'h00, {6'h00, k[1:0], 8'h00});
            n = 0;
            repeat (8) begin
                mid();
                n += sample_tick_o;
                step();
            end
            chk(n, (k == 1) ? 4 : 2);
        end
    endtask
    // centre modes gate compare flags by direction; direction bit frozen
    task automatic t_align();
        for (int a = 1; a < 4; a++) begin
            wr(8'h00, {9'h000, a[1:0], 5'h00});
            wr(8'h00, {9'h000, a[1:0], 5'h10});
            rdc(8'h00, {9'h000, a[1:0], 5'h00});
            chk(alignment_o, a[1:0]);
            for (int d = 0; d < 2; d++) begin
                count_down_i <= d[0];
                mid();
                chk(cmp_flag_enable_o, a == 3 || (a == 1) == d[0]);
                chk(count_down_o, d[0]);
                step();
            end
            // back to up so the next read sees a clear direction bit
            count_down_i <= 1'h0;
        end
        wr(8'h00, 16'h0000);
    endtask
    // debug halt freezes the run signal only when configured to
    task automatic t_debug();
        wr(8'h00, 16'h0001);
        debug_halt_i <= 1'h1;
        debug_stop_cfg_i <= 1'h1;
        mid();
        chk(counter_run_signal_o, 1'h0);
        step();
        debug_stop_cfg_i <= 1'h0;
        mid();
        chk(counter_run_signal_o, 1'h1);
        step();
        debug_halt_i <= 1'h0;
        wr(8'h00, 16'h0000);
    endtask
    // one update cause for a cycle: software bit or slave controller
    task automatic cause(input bit sw, input logic ev, input logic rq, input logic ri);
        if (sw) software_update_generate_i <= 1'h1;
        else slave_update_i <= 1'h1;
        mid();
        chk(update_event_o, ev);
        chk(update_req_o, rq);
        chk(counter_reinit_o, ri);
        step();
        software_update_generate_i <= 1'h0;
        slave_update_i <= 1'h0;
        step();
    endtask
    task automatic t_update();
        wr(8'h2C, 16'h1234);
        chk(auto_reload_value_o, 16'h1234);
        wr(8'h00, 16'h0080);
        wr(8'h2C, 16'h5678);
        chk(auto_reload_value_o, 16'h1234);
        cause(1'b0, 1'h1, 1'h1, 1'h0);
        chk(auto_reload_value_o, 16'h5678);
        wr(8'h00, 16'h0084);
        cause(1'b1, 1'h1, 1'h0, 1'h1);
        wr(8'h00, 16'h0082);
        wr(8'h2C, 16'h9ABC);
        cause(1'b1, 1'h0, 1'h0, 1'h1);
        chk(auto_reload_value_o, 16'h5678);
        wr(8'h00, 16'h0000);
    endtask
    // single pulse stops at update; trigger mode restarts in hardware
    task automatic t_single();
        wr(8'h00, 16'h0009);
        overflow_i <= 1'h1;
        step();
        overflow_i <= 1'h0;
        step();
        rdc(8'h00, 16'h0008);
        trigger_mode_i <= 1'h1;
        trigger_edge_i <= 1'h1;
        step();
        trigger_edge_i <= 1'h0;
        step();
        rdc(8'h00, 16'h0009);
        trigger_mode_i <= 1'h0;
        wr(8'h00, 16'h0000);
    endtask
    // every master output selection with its own cause, one cycle late
    task automatic t_trig();
        logic [7:0] e0;
        e0 = edges;
        for (int m = 0; m < 8; m++) begin
            wr(8'h04, {9'h000, m[2:0], 4'h0});
            case (m)
                0: software_update_generate_i <= 1'h1;
                1: {gated_mode_i, trigger_input_i, master_slave_sync_i} <= 3'h7;
                2: overflow_i <= 1'h1;
                3: channel1_flag_set_i <= 1'h1;
                default: compare_ref_i <= 4'h1 << (m - 4);
            endcase
            step();
            {software_update_generate_i, overflow_i, channel1_flag_set_i} <= 3'h0;
            {gated_mode_i, trigger_input_i} <= 2'h0; // sync stays on: no delayed gate echo
            compare_ref_i <= 4'h0;
            mid();
            chk(trigger_output_o, 1'h1);
            step();
            mid();
            chk(trigger_output_o, 1'h0);
            step();
        end
        chk(edges, e0 + 8'h08);
    endtask
    // dma timing, commutation preload, idle levels, input combine
    task automatic t_chan();
        for (int s = 0; s < 2; s++) begin
            wr(8'h04, {12'h000, s[0], 3'h0});
            cc_event_i <= 4'h5;
            step();
            cc_event_i <= 4'h0;
            mid();
            chk(cc_dma_req_o, s ? 4'h0 : 4'h5);
            step();
        end
        wr(8'h04, 16'h0001);
        wr(8'h30, 16'h00AB);
        chk(chan_ctrl_o, 16'h0000);
        software_commutation_i <= 1'h1;
        mid();
        chk(commutation_o, 1'h1);
        step();
        software_commutation_i <= 1'h0;
        mid();
        chk(chan_ctrl_o, 16'h00AB);
        step();
        wr(8'h04, 16'h0005);
        wr(8'h30, 16'h00CD);
        trigger_edge_i <= 1'h1;
        step();
        trigger_edge_i <= 1'h0;
        mid();
        chk(chan_ctrl_o, 16'h00CD);
        step();
        wr(8'h04, 16'h5580);
        chan_drive_i <= 7'h2A;
        chan_pins_i <= 3'h3;
        {main_output_enable_i, dead_time_done_i} <= 2'h3;
        repeat (5) step();
        chk(chan_out_o, 7'h2A);
        chk(ti1_o, 1'h0);
        main_output_enable_i <= 1'h0;
        wr(8'h04, 16'h5500);
        repeat (4) step();
        chk(chan_out_o, 7'h55);
        chk(ti1_o, 1'h1);
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (20) step();
        rst_i <= 1'h0;
        step();
        t_regs();
        t_align();
        t_debug();
        t_update();
        t_single();
        t_trig();
        t_chan();
        wrap_up();
    end
endmodule
